// ### hdl/mac_flow_pkg.sv
// Package: register map, field layout, reset values and timing for the
// pause flow-control and VLAN tag block.
// Assumes a 32-bit AXI4-Lite register bus and a byte-wide receive stream.
`default_nettype none
package mac_flow_pkg;
    localparam logic [7:0]  PAUSE_FLOW_CONTROL_OFS = 8'h9C;
    localparam logic [7:0]  VLAN_TAG_FIRST_OFS     = 8'hA0;
    localparam logic [7:0]  VLAN_TAG_SECOND_OFS    = 8'hA4;
    localparam logic [7:0]  LINK_MODE_OFS          = 8'hB4;
    localparam logic [7:0]  RX_TAG_STATUS_OFS      = 8'hB8;
    localparam int          FC_BUSY_BIT            = 0;
    localparam int          FC_ENABLE_BIT          = 1;
    localparam int          FC_PASS_BIT            = 2;
    localparam int          FC_TIME_LSB            = 16;
    localparam logic [15:0] PAUSE_TIME_RESET       = 16'h0000;
    localparam logic [15:0] TAG_ID_RESET           = 16'hFFFF;
    localparam logic [10:0] UNTAGGED_MAX_LEN       = 11'd1518;
    localparam logic [10:0] TAGGED_MAX_LEN         = 11'd1522;
    localparam logic [15:0] MAC_CONTROL_TYPE       = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE           = 16'h0001;
    localparam int          CORE_CLK_MHZ           = 100;
    localparam int          QUANTUM_BITS           = 512;
    localparam int          BIT_NS_100M            = 10;
    localparam int          BIT_NS_10M             = 100;
    localparam int          QUANTUM_CYC_100M       = QUANTUM_BITS * BIT_NS_100M * CORE_CLK_MHZ / 1000;
    localparam int          QUANTUM_CYC_10M        = QUANTUM_BITS * BIT_NS_10M * CORE_CLK_MHZ / 1000;
    localparam int          PAUSE_FRAME_BYTES      = 60;
    localparam int          BYTE_POS_TAG_HI        = 12;
    localparam int          BYTE_POS_TAG_LO        = 13;
    localparam int          BYTE_POS_OPC_LO        = 15;
    localparam int          BYTE_POS_TIME_LO       = 17;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
        logic       crcOk;
    } rx_byte_t;

    typedef struct packed {
        logic        done;
        logic        isPause;
        logic        tag1;
        logic        tag2;
        logic        tooLong;
        logic        filterBit;
        logic [15:0] pauseTime;
    } rx_status_t;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } tx_byte_t;
endpackage
`default_nettype wire

// ### hdl/mac_pause_sender.sv
// Serialises one PAUSE control frame (header, opcode, pause time, padding).
// Assumes the transmit sink takes a byte on any cycle that txReady is high.
`default_nettype none
module mac_pause_sender
    import mac_flow_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    // Control
    input  wire logic        start,
    input  wire logic [15:0] pauseTime,
    output logic             busy,
    output logic             done,
    // Transmit stream
    output tx_byte_t         txOut,
    input  wire logic        txReady
);
    logic [5:0] idx_r;
    logic       busy_r;
    logic [7:0] byteSel;
    wire        step = clkEn && busy_r && txReady;
    wire        last = (idx_r == 6'(PAUSE_FRAME_BYTES - 1));

    // Reserved multicast destination, then type and opcode
    always_comb
    begin
        unique case (idx_r)
            6'd0:    byteSel = 8'h01;
            6'd1:    byteSel = 8'h80;
            6'd2:    byteSel = 8'hC2;
            6'd5:    byteSel = 8'h01;
            6'd12:   byteSel = MAC_CONTROL_TYPE[15:8];
            6'd13:   byteSel = MAC_CONTROL_TYPE[7:0];
            6'd14:   byteSel = PAUSE_OPCODE[15:8];
            6'd15:   byteSel = PAUSE_OPCODE[7:0];
            6'd16:   byteSel = pauseTime[15:8];
            6'd17:   byteSel = pauseTime[7:0];
            default: byteSel = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_r <= 1'b0;
            idx_r  <= 6'h00;
        end
        else if (clkEn && start && !busy_r)
        begin
            busy_r <= 1'b1;
            idx_r  <= 6'h00;
        end
        else if (step)
        begin
            idx_r  <= last ? 6'h00 : idx_r + 6'h01;
            busy_r <= !last;
        end
    end

    assign busy        = busy_r;
    assign done        = step && last;
    // One driver for the whole struct
    assign txOut = '{valid: busy_r, last: busy_r && last, data: busy_r ? byteSel : 8'h00};
endmodule
`default_nettype wire

// ### hdl/mac_rx_inspect.sv
// Watches the receive byte stream: VLAN tag match, length, PAUSE decode.
// Assumes bytes arrive from logic on core_clk, frame start after a last.
`default_nettype none
module mac_rx_inspect
    import mac_flow_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    // Settings
    input  wire logic [15:0] tagFirst,
    input  wire logic [15:0] tagSecond,
    // Stream and result
    input  wire rx_byte_t    rxIn,
    output rx_status_t       stat
);
    logic [10:0] cnt_r;
    logic [15:0] tag_r;
    logic [15:0] opc_r;
    logic [15:0] tim_r;
    rx_status_t  stat_r;
    wire         take = clkEn && rxIn.valid;
    wire         t1 = (tag_r == tagFirst);
    wire         t2 = (tag_r == tagSecond);
    wire [10:0]  len = cnt_r + 11'd1;
    wire [10:0]  maxLen = (t1 || t2) ? TAGGED_MAX_LEN : UNTAGGED_MAX_LEN;
    wire         pause = (tag_r == MAC_CONTROL_TYPE) && (opc_r == PAUSE_OPCODE)
                         && rxIn.crcOk && (len >= 11'd64);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r  <= 11'h000;
            tag_r  <= 16'h0000;
            opc_r  <= 16'h0000;
            tim_r  <= 16'h0000;
            stat_r <= '0;
        end
        else if (clkEn)
        begin
            stat_r.done <= take && rxIn.last;
            if (take)
            begin
                cnt_r <= rxIn.last ? 11'h000 : (cnt_r == 11'h7FF ? cnt_r : len);
                if (cnt_r <= 11'(BYTE_POS_TAG_LO) && cnt_r >= 11'(BYTE_POS_TAG_HI))
                    tag_r <= {tag_r[7:0], rxIn.data};
                if (cnt_r <= 11'(BYTE_POS_OPC_LO) && cnt_r > 11'(BYTE_POS_TAG_LO))
                    opc_r <= {opc_r[7:0], rxIn.data};
                if (cnt_r <= 11'(BYTE_POS_TIME_LO) && cnt_r > 11'(BYTE_POS_OPC_LO))
                    tim_r <= {tim_r[7:0], rxIn.data};
                if (rxIn.last)
                begin
                    stat_r.isPause   <= pause;
                    stat_r.tag1      <= t1;
                    stat_r.tag2      <= t2;
                    stat_r.tooLong   <= len > maxLen;
                    stat_r.pauseTime <= tim_r;
                end
            end
        end
    end

    assign stat = '{done: stat_r.done, isPause: stat_r.isPause, tag1: stat_r.tag1,
                    tag2: stat_r.tag2, tooLong: stat_r.tooLong, filterBit: 1'b0,
                    pauseTime: stat_r.pauseTime};
endmodule
`default_nettype wire

// ### hdl/mac_pause_flow.sv
// Top: AXI4-Lite registers, PAUSE generation, PAUSE reception hold-off
// and VLAN tag recognition. Assumes full/half duplex and speed come from
// the link mode register; receive bytes and tx gating on core_clk.
// Contract
// - Busy-bit write starts a PAUSE frame
// - Pause-time field comes from upper half
// - Pass bit drives packet-filter status on pause
// - Every received frame is forwarded
// - Promiscuous filtering overrides pass bit
// - Valid pause holds transmitter time times slot
// - Enable clear: no decode, no pause; tag status register still shows decoded pause
// - Pause send and receive only full duplex
// - First tag identifier match, resets all ones
// - Second tag identifier match, resets all ones
// - Tagged frames allow 1522 bytes
// - Checksum engine uses first tag identifier
`default_nettype none
module mac_pause_flow
    import mac_flow_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Receive stream in, forwarded stream and status out
    input  wire rx_byte_t    rxIn,
    output rx_byte_t         rxFwd,
    output rx_status_t       rxStatus,
    input  wire logic        promiscuous,
    // Transmit side, and first tag identifier out
    output tx_byte_t         pauseTx,
    input  wire logic        pauseTxReady,
    output logic             txHold,
    output logic [15:0]      rxVlanProtocol
);
    // Register state
    logic [15:0] pauseTime_r;
    logic        passCtl_r;
    logic        fcEnable_r;
    logic [15:0] tagFirst_r;
    logic [15:0] tagSecond_r;
    logic        fullDuplex_r;
    logic        speed100_r;
    logic [3:0]  lastTag_r;
    // Bus state
    logic        awHave_r;
    logic [7:0]  awAddr_r;
    logic        wHave_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;
    logic        bValid_r;
    logic [1:0]  bResp_r;
    logic        rValid_r;
    logic [31:0] rData_r;
    logic [1:0]  rResp_r;
    // Hold-off and receive forwarding
    logic [15:0] quanta_r;
    logic [12:0] qCnt_r;
    rx_byte_t    rxFwd_r;
    rx_status_t  rxStatus_r;

    logic        sendBusy;
    logic        sendDone;
    rx_status_t  inspStat;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                res[8*i +: 8] = nw[8*i +: 8];
        return res;
    endfunction

    function automatic logic known(input logic [7:0] a);
        return a == PAUSE_FLOW_CONTROL_OFS || a == VLAN_TAG_FIRST_OFS ||
               a == VLAN_TAG_SECOND_OFS || a == LINK_MODE_OFS || a == RX_TAG_STATUS_OFS;
    endfunction

    // Write path: address and data taken in either order
    assign s_axi_awready = !awHave_r && !bValid_r;
    assign s_axi_wready  = !wHave_r && !bValid_r;
    wire        doWrite  = clkEn && awHave_r && wHave_r && !bValid_r;
    wire [31:0] flowWord = {pauseTime_r, 13'h0000, passCtl_r, fcEnable_r, sendBusy};
    wire [31:0] flowNew  = merge(flowWord, wData_r, wStrb_r);
    wire        wrFlow   = doWrite && awAddr_r == PAUSE_FLOW_CONTROL_OFS;
    // Flow register writes while busy are ignored; software is expected to poll first
    wire        startSend = wrFlow && flowNew[FC_BUSY_BIT] && !sendBusy
                            && fullDuplex_r;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awHave_r <= 1'b0;
            awAddr_r <= 8'h00;
            wHave_r  <= 1'b0;
            wData_r  <= 32'h0000_0000;
            wStrb_r  <= 4'h0;
            bValid_r <= 1'b0;
            bResp_r  <= 2'b00;
        end
        else if (clkEn)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHave_r <= 1'b1;
                awAddr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHave_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHave_r <= 1'b0;
                wHave_r  <= 1'b0;
                bValid_r <= 1'b1;
                bResp_r  <= known(awAddr_r) ? 2'b00 : 2'b10;
            end
            else if (bValid_r && s_axi_bready)
                bValid_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pauseTime_r  <= PAUSE_TIME_RESET;
            passCtl_r    <= 1'b0;
            fcEnable_r   <= 1'b0;
            tagFirst_r   <= TAG_ID_RESET;
            tagSecond_r  <= TAG_ID_RESET;
            fullDuplex_r <= 1'b0;
            speed100_r   <= 1'b1;
        end
        else if (doWrite && !sendBusy && awAddr_r == PAUSE_FLOW_CONTROL_OFS)
        begin
            pauseTime_r <= flowNew[31:FC_TIME_LSB];
            passCtl_r   <= flowNew[FC_PASS_BIT];
            fcEnable_r  <= flowNew[FC_ENABLE_BIT];
        end
        else if (doWrite && awAddr_r == VLAN_TAG_FIRST_OFS)
            tagFirst_r <= 16'(merge({16'h0000, tagFirst_r}, wData_r, wStrb_r));
        else if (doWrite && awAddr_r == VLAN_TAG_SECOND_OFS)
            tagSecond_r <= 16'(merge({16'h0000, tagSecond_r}, wData_r, wStrb_r));
        else if (doWrite && awAddr_r == LINK_MODE_OFS && wStrb_r[0])
        begin
            fullDuplex_r <= wData_r[0];
            speed100_r   <= wData_r[1];
        end
    end

    // Read path
    assign s_axi_arready = !rValid_r;
    wire [31:0] rdMux =
        (s_axi_araddr[7:2] == PAUSE_FLOW_CONTROL_OFS[7:2]) ? flowWord :
        (s_axi_araddr[7:2] == VLAN_TAG_FIRST_OFS[7:2])     ? {16'h0000, tagFirst_r} :
        (s_axi_araddr[7:2] == VLAN_TAG_SECOND_OFS[7:2])    ? {16'h0000, tagSecond_r} :
        (s_axi_araddr[7:2] == LINK_MODE_OFS[7:2])          ? {30'h0, speed100_r, fullDuplex_r} :
        (s_axi_araddr[7:2] == RX_TAG_STATUS_OFS[7:2])      ? {27'h0, txHold, lastTag_r} :
        32'h0000_0000;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rValid_r <= 1'b0;
            rData_r  <= 32'h0000_0000;
            rResp_r  <= 2'b00;
        end
        else if (clkEn)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                rValid_r <= 1'b1;
                rData_r  <= rdMux;
                rResp_r  <= known({s_axi_araddr[7:2], 2'b00}) ? 2'b00 : 2'b10;
            end
            else if (rValid_r && s_axi_rready)
                rValid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp  = bResp_r;
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rdata  = rData_r;
    assign s_axi_rresp  = rResp_r;

    mac_pause_sender u_sender (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .clkEn     (clkEn),
        .start     (startSend),
        .pauseTime (pauseTime_r),
        .busy      (sendBusy),
        .done      (sendDone),
        .txOut     (pauseTx),
        .txReady   (pauseTxReady)
    );

    mac_rx_inspect u_inspect (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .clkEn     (clkEn),
        .tagFirst  (tagFirst_r),
        .tagSecond (tagSecond_r),
        .rxIn      (rxIn),
        .stat      (inspStat)
    );

    // Hold-off: quanta counted down, each quantum 512 bit times
    wire        pauseSeen = inspStat.isPause && fcEnable_r && fullDuplex_r;
    wire        doPause   = inspStat.done && pauseSeen;
    wire [12:0] qLen      = speed100_r ? 13'(QUANTUM_CYC_100M) : 13'(QUANTUM_CYC_10M);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            quanta_r <= 16'h0000;
            qCnt_r   <= 13'h0000;
        end
        else if (clkEn)
        begin
            if (doPause)
            begin
                quanta_r <= inspStat.pauseTime;
                qCnt_r   <= 13'h0000;
            end
            else if (!fcEnable_r || !fullDuplex_r)
                quanta_r <= 16'h0000;
            else if (quanta_r != 16'h0000)
            begin
                qCnt_r <= (qCnt_r == qLen - 13'h0001) ? 13'h0000 : qCnt_r + 13'h0001;
                if (qCnt_r == qLen - 13'h0001)
                    quanta_r <= quanta_r - 16'h0001;
            end
        end
    end

    assign txHold = quanta_r != 16'h0000;

    // Forward every byte; status after last byte
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxFwd_r    <= '0;
            rxStatus_r <= '0;
            lastTag_r  <= 4'h0;
        end
        else if (clkEn)
        begin
            rxFwd_r <= rxIn;
            rxStatus_r <= inspStat;
            rxStatus_r.isPause <= pauseSeen;
            // Promiscuous wins, else pass bit marks pause frames
            rxStatus_r.filterBit <= promiscuous ? 1'b1 :
                                    (passCtl_r && pauseSeen);
            if (inspStat.done)
                lastTag_r <= {inspStat.tooLong, inspStat.isPause, inspStat.tag2, inspStat.tag1};
        end
    end

    assign rxFwd          = rxFwd_r;
    assign rxStatus       = rxStatus_r;
    assign rxVlanProtocol = tagFirst_r;

    a_busy_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && sendDone |=> !sendBusy)
        else $error("busy not cleared after pause frame");
    a_busy_sets: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && startSend |=> sendBusy)
        else $error("pause send did not start");
    a_no_hold_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        !fcEnable_r && $past(!fcEnable_r) |-> !txHold)
        else $error("transmitter held while flow control off");
    a_half_no_send: assert property (@(posedge core_clk) disable iff (!rst_n)
        !fullDuplex_r |-> !startSend)
        else $error("pause sent in half duplex");
    a_pause_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && doPause && inspStat.pauseTime != 16'h0000 |=> txHold [*2])
        else $error("hold-off not started");
    a_filter_pass: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && !promiscuous && !passCtl_r && inspStat.isPause |=> !rxStatus.filterBit)
        else $error("filter bit set with pass clear");
    a_promisc_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && promiscuous |=> rxStatus.filterBit)
        else $error("promiscuous did not win");
    a_fwd_data: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && rxIn.valid |=> rxFwd.valid && rxFwd.data == $past(rxIn.data))
        else $error("byte not forwarded");
    a_tag_reset: assert property (@(posedge core_clk)
        $rose(rst_n) |-> tagFirst_r == TAG_ID_RESET && tagSecond_r == TAG_ID_RESET)
        else $error("tag identifiers not all ones");
    c_pause_sent: cover property (@(posedge core_clk) sendDone);
    c_pause_rx: cover property (@(posedge core_clk) doPause);
    c_tagged: cover property (@(posedge core_clk) inspStat.done && inspStat.tag1);
endmodule
`default_nettype wire

// ### tb/mac_link_partner.sv
// Link partner model: sends receive frames and takes PAUSE frame bytes.
// Assumes rxIn and pauseTxReady are sampled on rising core_clk edges.
`default_nettype none
module mac_link_partner
    import mac_flow_pkg::*;
(
    // Clock
    input  wire logic     core_clk,
    // Receive side
    output var rx_byte_t  rxIn,
    // Transmit side
    input  wire tx_byte_t pauseTx,
    output var logic      pauseTxReady
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] txBuf [0:63];
    int         txCnt = 0;
    logic       lastOk = 1'b0;

    initial rxIn = '0;
    initial pauseTxReady = 1'b0;

    // Ready only every other cycle, so the sender must cope with stalls
    always @(posedge core_clk)
    begin
        pauseTxReady <= ~pauseTxReady;
        if (pauseTx.valid && pauseTxReady && txCnt < 64)
        begin
            txBuf[txCnt] <= pauseTx.data;
            txCnt <= txCnt + 1;
            lastOk <= pauseTx.last && (txCnt == 59);
        end
    end

    // Type at bytes 13-14, opcode 15-16, pause time 17-18, then filler
    task automatic send_frame(input logic [15:0] typ, input logic [15:0] opc,
                              input logic [15:0] tm, input int len, input logic crc);
        logic [7:0] b;
        for (int i = 0; i < len; i++)
        begin
            b = (i == 12) ? typ[15:8] : (i == 13) ? typ[7:0] : (i == 14) ? opc[15:8] :
                (i == 15) ? opc[7:0] : (i == 16) ? tm[15:8] : (i == 17) ? tm[7:0] : i[7:0];
            @(posedge core_clk);
            rxIn <= '{valid: 1'b1, last: (i == len - 1), data: b, crcOk: crc};
        end
        @(posedge core_clk);
        // Idle data is the inverse of the last byte, never a held copy of it
        rxIn <= '{valid: 1'b0, last: 1'b0, data: ~b, crcOk: 1'b0};
    endtask
endmodule
`default_nettype wire

// ### tb/mac_pause_flow_and_vlan_tags_tb.sv
// Bench for the pause flow-control and VLAN tag block.
// Assumes the link partner model and the package from hdl/.
`default_nettype none
module mac_pause_flow_and_vlan_tags_tb;
    import mac_flow_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        promiscuous = 1'b0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    rx_byte_t    rxIn, rxFwd;
    rx_status_t  rxStatus;
    tx_byte_t    pauseTx;
    logic        pauseTxReady, txHold;
    logic [15:0] rxVlanProtocol;
    logic [31:0] holdCnt = '0, fwdCnt = '0, d;
    logic [1:0]  r;
    int          badCount = 0, cmpCount = 0, sent = 0;

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) if (txHold) holdCnt <= holdCnt + 1;
    always @(posedge core_clk) if (rxFwd.valid) fwdCnt <= fwdCnt + 1;

    mac_pause_flow dut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rxIn(rxIn),
        .rxFwd(rxFwd), .rxStatus(rxStatus), .promiscuous(promiscuous), .pauseTx(pauseTx),
        .pauseTxReady(pauseTxReady), .txHold(txHold), .rxVlanProtocol(rxVlanProtocol));

    mac_link_partner partner (.core_clk(core_clk), .rxIn(rxIn), .pauseTx(pauseTx),
        .pauseTxReady(pauseTxReady));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            badCount++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrapUp();
        if (badCount == 0 && cmpCount > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Handshake flags are looked at mid-cycle, acted on at the next edge
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] v);
        logic aw, w, b;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge core_clk);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            @(posedge core_clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end while (!b);
    endtask

    task automatic axiRead(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
        logic ar, rv;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge core_clk);
            ar = s_axi_arready;
            rv = s_axi_rvalid;
            v = s_axi_rdata;
            e = s_axi_rresp;
            @(posedge core_clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (rv) s_axi_rready <= 1'b0;
        end while (!rv);
    endtask

    // Busy must read clear before any flow register write
    task automatic flowWrite(input logic [31:0] v);
        axiRead(PAUSE_FLOW_CONTROL_OFS, d, r);
        chk({31'h0, d[0]}, 32'h0);
        axiWrite(PAUSE_FLOW_CONTROL_OFS, v);
    endtask

    // Flags are {isPause, tag1, tag2, tooLong, filterBit}
    task automatic rxCase(input logic [15:0] typ, input int len, input logic crc,
                          input logic [4:0] mask, input logic [4:0] exp,
                          input logic [31:0] hold);
        rx_status_t st;
        @(posedge core_clk);
        holdCnt <= '0;
        partner.send_frame(typ, PAUSE_OPCODE, 16'h0002, len, crc);
        sent += len;
        do
        begin
            @(negedge core_clk);
            st = rxStatus;
        end while (st.done !== 1'b1);
        chk({27'h0, mask & {st.isPause, st.tag1, st.tag2, st.tooLong, st.filterBit}},
            {27'h0, mask & exp});
        repeat (1100) @(posedge core_clk);
        chk(holdCnt, hold);
    endtask

    initial
    begin
        // Covers the longest run with a wide margin
        #900000;
        badCount++;
        wrapUp();
    end

    initial
    begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        axiRead(VLAN_TAG_FIRST_OFS, d, r);
        chk(d, 32'h0000FFFF);
        axiRead(VLAN_TAG_SECOND_OFS, d, r);
        chk(d, 32'h0000FFFF);
        chk({16'h0, rxVlanProtocol}, 32'h0000FFFF);
        axiRead(8'h10, d, r);
        chk({30'h0, r}, 32'h2);
        axiWrite(LINK_MODE_OFS, 32'h3);
        flowWrite(32'h1234_0007);
        axiRead(PAUSE_FLOW_CONTROL_OFS, d, r);
        chk({31'h0, d[0]}, 32'h1);
        for (int i = 0; i < 100 && d[0] !== 1'b0; i++)
            axiRead(PAUSE_FLOW_CONTROL_OFS, d, r);
        chk(d, 32'h1234_0006);
        chk(partner.txCnt, 32'd60);
        chk({16'h0, partner.txBuf[12], partner.txBuf[13]}, 32'h8808);
        chk({16'h0, partner.txBuf[16], partner.txBuf[17]}, 32'h1234);
        chk({31'h0, partner.lastOk}, 32'h1);
        // Two quanta of 512 bit times at 10 ns each
        rxCase(16'h8808, 64, 1'b1, 5'h1F, 5'b10001, 32'd1024);
        rxCase(16'h8808, 64, 1'b0, 5'h1F, 5'b00000, 32'd0);
        flowWrite(32'h0000_0002);
        rxCase(16'h8808, 64, 1'b1, 5'h1F, 5'b10000, 32'd1024);
        promiscuous <= 1'b1;
        rxCase(16'h8808, 64, 1'b1, 5'h01, 5'b00001, 32'd1024);
        promiscuous <= 1'b0;
        flowWrite(32'h0000_0004);
        rxCase(16'h8808, 64, 1'b1, 5'h1F, 5'b00000, 32'd0);
        axiWrite(LINK_MODE_OFS, 32'h2);
        flowWrite(32'h0000_0002);
        rxCase(16'h8808, 64, 1'b1, 5'h1F, 5'b00000, 32'd0);
        flowWrite(32'h0001_0003);
        repeat (150) @(posedge core_clk);
        chk(partner.txCnt, 32'd60);
        axiWrite(LINK_MODE_OFS, 32'h3);
        // Receive path idle while the tags change
        axiWrite(VLAN_TAG_FIRST_OFS, 32'h0000_8100);
        axiWrite(VLAN_TAG_SECOND_OFS, 32'h0000_9100);
        chk({16'h0, rxVlanProtocol}, 32'h8100);
        rxCase(16'h8100, 1522, 1'b1, 5'h1E, 5'b01000, 32'd0);
        rxCase(16'h9100, 1523, 1'b1, 5'h1E, 5'b00110, 32'd0);
        rxCase(16'h0800, 1519, 1'b1, 5'h1E, 5'b00010, 32'd0);
        rxCase(16'h0800, 1518, 1'b0, 5'h1E, 5'b00000, 32'd0);
        chk(fwdCnt, sent);
        wrapUp();
    end
endmodule
`default_nettype wire
